// *** logic/mtdm_mapper.sv ***
// Modbus-TCP request checker and register/coil to byte address mapper.
// Assumes a TCP stack that hands over decoded requests and connection
// events on this clock, and a memory engine that carries out the answer.
// How it works
// - Admit at most CONN connections (eight by default), and only those on TCP port 502.
// - Two modes, standard by default; standard mode refuses coil functions.
// - Function unsupported in the active mode answers exception 0x01.
// - Range outside the initialised area answers exception 0x02.
// - Bad quantity or coil value answers exception 0x03.
// - Standard: fc3 reads output, fc4 reads input, 1 to 125 registers.
// - Standard: fc6, fc16 (1-800) and fc22 write the output area only.
// - Standard: fc23 reads up to 125 and writes up to 100 registers.
// - Standard input register N sits at byte 2*(N-1).
// - Standard holding register N sits at 0x200 plus 2*(N-1).
// - Alternative: fc1/fc2 read 1-2000 bits, fc3/fc4 1-125 registers, any area.
// - Alternative: fc5, fc15, fc16 (1-100), fc6, fc22 write output area only.
// - Alternative: fc23 reads 125, writes 100, over the whole range.
// - Alternative: registers 1-256 input, 257-1024 reserved, 1025-1280 output.
// - Coils go MSB first: first coil of a register is bit 15.
// - Alternative numbering is the same for every function code.
// - Coil and register functions reach the same bytes.
`timescale 1ns/100ps
module mtdm_mapper #(
  parameter int CONN = mtdm_pkg::CONN_DFLT
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Connection admission
  input wire logic conn_open_i,
  input wire logic [15:0] conn_port_i,
  input wire logic conn_close_i,
  input wire logic [$clog2(CONN)-1:0] conn_close_id_i,
  output logic conn_ack_o,
  output logic conn_nak_o,
  output logic [$clog2(CONN)-1:0] conn_id_o,
  // Configuration
  input wire logic alt_mode_i,
  input wire logic [9:0] in_size_i,
  input wire logic [9:0] out_size_i,
  // Request
  input wire logic req_valid_i,
  input wire logic [$clog2(CONN)-1:0] req_conn_i,
  input wire logic [7:0] req_func_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_qty_i,
  input wire logic [15:0] req_waddr_i,
  input wire logic [15:0] req_wqty_i,
  input wire logic [15:0] req_value_i,
  // Answer
  output logic rsp_valid_o,
  output logic [$clog2(CONN)-1:0] rsp_conn_o,
  output logic [7:0] rsp_func_o,
  output logic [7:0] rsp_exc_o,
  output logic rsp_coil_o,
  output logic rsp_rd_en_o,
  output logic [9:0] rsp_rd_addr_o,
  output logic [2:0] rsp_rd_bit_o,
  output logic [15:0] rsp_rd_cnt_o,
  output logic rsp_wr_en_o,
  output logic [9:0] rsp_wr_addr_o,
  output logic [2:0] rsp_wr_bit_o,
  output logic [15:0] rsp_wr_cnt_o
);
  localparam int CW = $clog2(CONN);

  if (CONN < 2 || CONN > 256) begin : g_chk
    $error("CONN must lie in 2..256");
  end

  typedef struct packed {
    logic [CONN-1:0] open;
    logic ack;
    logic nak;
    logic [CW-1:0] cid;
    logic vld;
    logic [CW-1:0] conn;
    logic [7:0] func;
    logic [7:0] exc;
    logic coil;
    logic rd_en;
    logic [9:0] rd_addr;
    logic [2:0] rd_bit;
    logic [15:0] rd_cnt;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [2:0] wr_bit;
    logic [15:0] wr_cnt;
  } mtdm_st_t;

  mtdm_st_t st_r;
  mtdm_st_t st_nxt;

  // {hit, output area, byte address}; index low bits equal in both modes
  function automatic logic [11:0] reg_loc(input logic alt, input logic sout, input logic [16:0] r);
    logic hit;
    logic out;
    hit = 1'b0;
    out = sout;
    if (!alt) begin
      hit = r < mtdm_pkg::AREA_REGS;
    end else if (r < mtdm_pkg::AREA_REGS) begin
      hit = 1'b1;
      out = 1'b0;
    end else if (r >= mtdm_pkg::ALT_OUT_FIRST && r < mtdm_pkg::ALT_OUT_END) begin
      hit = 1'b1;
      out = 1'b1;
    end
    reg_loc = {hit, out, (out ? mtdm_pkg::OUT_BASE : 10'h000) | {1'b0, r[7:0], 1'b0}};
  endfunction : reg_loc

  // Whole span in one area, allowed, and inside the initialised bytes
  function automatic logic span_ok(input logic alt, input logic sout, input logic [16:0] f, input logic [16:0] l,
                                   input logic [9:0] isz, input logic [9:0] osz, input logic need_out);
    logic [11:0] lf;
    logic [11:0] ll;
    logic [9:0] sz;
    lf = reg_loc(alt, sout, f);
    ll = reg_loc(alt, sout, l);
    sz = ll[10] ? osz : isz;
    span_ok = lf[11] && ll[11] && lf[10] == ll[10] && !(need_out && !ll[10])
              && {1'b0, ll[8:1], 1'b1} < sz;
  endfunction : span_ok

  function automatic logic qty_ok(input logic [15:0] q, input logic [15:0] mx);
    qty_ok = q != 16'h0000 && q <= mx;
  endfunction : qty_ok

  // Coil byte and bit: high byte first, MSB first within the register
  function automatic logic [12:0] coil_pos(input logic [9:0] rb, input logic [3:0] k);
    coil_pos = {rb + {9'h000, k[3]}, mtdm_pkg::BIT_MSB - k[2:0]};
  endfunction : coil_pos

  logic [CW-1:0] free_id;
  logic free_hit;
  logic live;
  logic sup;
  logic rd;
  logic wr;
  logic coil;
  logic rout;
  logic need_out;
  logic [15:0] rmax;
  logic [15:0] wmax;
  logic [15:0] wa;
  logic [15:0] wq;
  logic [16:0] rf;
  logic [16:0] rl;
  logic [16:0] wf;
  logic [16:0] wl;
  logic [16:0] csum;
  logic [11:0] rloc;
  logic [11:0] wloc;
  logic [12:0] rcp;
  logic [12:0] wcp;
  logic val_bad;

  assign live = st_r.open[req_conn_i];

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.nak = 1'b0;
    st_nxt.vld = 1'b0;
    free_hit = 1'b0;
    free_id = '0;
    for (int i = CONN - 1; i >= 0; i--) begin
      if (!st_r.open[i]) begin
        free_hit = 1'b1;
        free_id = CW'(i);
      end
    end
    if (conn_close_i) begin
      st_nxt.open[conn_close_id_i] = 1'b0;
    end
    if (conn_open_i) begin
      if (conn_port_i == mtdm_pkg::TCP_PORT && free_hit) begin
        st_nxt.open[free_id] = 1'b1;
        st_nxt.ack = 1'b1;
        st_nxt.cid = free_id;
      end else begin
        st_nxt.nak = 1'b1;
      end
    end

    // Per-function profile
    sup = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    coil = 1'b0;
    rout = 1'b1;
    rmax = mtdm_pkg::QTY_RD_REG;
    wmax = mtdm_pkg::QTY_ONE;
    wa = req_addr_i;
    wq = req_qty_i;
    need_out = 1'b1;
    val_bad = 1'b0;
    case (req_func_i)
      mtdm_pkg::FC_RD_COILS, mtdm_pkg::FC_RD_DISC: begin
        sup = alt_mode_i;
        rd = 1'b1;
        coil = 1'b1;
        rmax = mtdm_pkg::QTY_RD_BIT;
      end
      mtdm_pkg::FC_RD_HOLD: rd = 1'b1;
      mtdm_pkg::FC_RD_INREG: begin
        rd = 1'b1;
        rout = 1'b0;
      end
      mtdm_pkg::FC_WR_COIL: begin
        sup = alt_mode_i;
        wr = 1'b1;
        coil = 1'b1;
        wq = mtdm_pkg::QTY_ONE;
        val_bad = req_value_i != mtdm_pkg::COIL_ON && req_value_i != mtdm_pkg::COIL_OFF;
      end
      mtdm_pkg::FC_WR_REG, mtdm_pkg::FC_MASK_WR: begin
        wr = 1'b1;
        wq = mtdm_pkg::QTY_ONE;
      end
      mtdm_pkg::FC_WR_MCOIL: begin
        sup = alt_mode_i;
        wr = 1'b1;
        coil = 1'b1;
        wmax = mtdm_pkg::QTY_WR_BIT;
      end
      mtdm_pkg::FC_WR_MREG: begin
        wr = 1'b1;
        wmax = alt_mode_i ? mtdm_pkg::QTY_WR_REG_ALT : mtdm_pkg::QTY_WR_REG_STD;
      end
      mtdm_pkg::FC_RW_REGS: begin
        rd = 1'b1;
        wr = 1'b1;
        wmax = mtdm_pkg::QTY_RW_WR;
        wa = req_waddr_i;
        wq = req_wqty_i;
        need_out = !alt_mode_i;
      end
      default: sup = 1'b0;
    endcase

    // Register spans; coils fold sixteen to a register
    csum = {1'b0, req_addr_i} + {1'b0, req_qty_i} - 17'h00001;
    rf = coil ? {5'h00, req_addr_i[15:mtdm_pkg::COIL_SHIFT]} : {1'b0, req_addr_i};
    rl = coil ? {4'h0, csum[16:mtdm_pkg::COIL_SHIFT]} : csum;
    csum = {1'b0, wa} + {1'b0, wq} - 17'h00001;
    wf = coil ? {5'h00, wa[15:mtdm_pkg::COIL_SHIFT]} : {1'b0, wa};
    wl = coil ? {4'h0, csum[16:mtdm_pkg::COIL_SHIFT]} : csum;
    rloc = reg_loc(alt_mode_i, rout, rf);
    wloc = reg_loc(alt_mode_i, 1'b1, wf);
    rcp = coil_pos(rloc[9:0], req_addr_i[3:0]);
    wcp = coil_pos(wloc[9:0], wa[3:0]);

    if (req_valid_i && live) begin
      st_nxt.vld = 1'b1;
      st_nxt.conn = req_conn_i;
      st_nxt.func = req_func_i;
      st_nxt.coil = coil;
      st_nxt.rd_en = 1'b0;
      st_nxt.wr_en = 1'b0;
      st_nxt.rd_addr = coil ? rcp[12:3] : rloc[9:0];
      st_nxt.rd_bit = coil ? rcp[2:0] : mtdm_pkg::BIT_MSB;
      st_nxt.rd_cnt = req_qty_i;
      st_nxt.wr_addr = coil ? wcp[12:3] : wloc[9:0];
      st_nxt.wr_bit = coil ? wcp[2:0] : mtdm_pkg::BIT_MSB;
      st_nxt.wr_cnt = wq;
      if (!sup) begin
        st_nxt.exc = mtdm_pkg::EX_FUNC;
      end else if ((rd && !qty_ok(req_qty_i, rmax)) || (wr && !qty_ok(wq, wmax)) || val_bad) begin
        st_nxt.exc = mtdm_pkg::EX_VALUE;
      end else if ((rd && !span_ok(alt_mode_i, rout, rf, rl, in_size_i, out_size_i, 1'b0))
                   || (wr && !span_ok(alt_mode_i, 1'b1, wf, wl, in_size_i, out_size_i, need_out))) begin
        st_nxt.exc = mtdm_pkg::EX_ADDR;
      end else begin
        st_nxt.exc = mtdm_pkg::EX_NONE;
        st_nxt.rd_en = rd;
        st_nxt.wr_en = wr;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conn_ack_o = st_r.ack;
  assign conn_nak_o = st_r.nak;
  assign conn_id_o = st_r.cid;
  assign rsp_valid_o = st_r.vld;
  assign rsp_conn_o = st_r.conn;
  assign rsp_func_o = st_r.func;
  assign rsp_exc_o = st_r.exc;
  assign rsp_coil_o = st_r.coil;
  assign rsp_rd_en_o = st_r.rd_en;
  assign rsp_rd_addr_o = st_r.rd_addr;
  assign rsp_rd_bit_o = st_r.rd_bit;
  assign rsp_rd_cnt_o = st_r.rd_cnt;
  assign rsp_wr_en_o = st_r.wr_en;
  assign rsp_wr_addr_o = st_r.wr_addr;
  assign rsp_wr_bit_o = st_r.wr_bit;
  assign rsp_wr_cnt_o = st_r.wr_cnt;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    req_valid_i && live;
  endsequence
  sequence s_one_reg;
    s_take ##0 req_qty_i == 16'h0001 && in_size_i >= 10'h200 && out_size_i >= 10'h200;
  endsequence

  property p_port_refused;
    conn_open_i && conn_port_i != mtdm_pkg::TCP_PORT |=> conn_nak_o && !conn_ack_o;
  endproperty
  a_port_refused: assert property (p_port_refused) else $error("foreign port admitted");
  property p_full_refused;
    conn_open_i && (&st_r.open) |=> conn_nak_o;
  endproperty
  a_full_refused: assert property (p_full_refused) else $error("ninth connection admitted");
  property p_std_no_coil;
    s_take ##0 !alt_mode_i && req_func_i == mtdm_pkg::FC_RD_COILS |=> rsp_exc_o == mtdm_pkg::EX_FUNC;
  endproperty
  a_std_no_coil: assert property (p_std_no_coil) else $error("coil read taken in standard mode");
  property p_bad_func;
    s_take ##0 req_func_i == 8'h07 |=> rsp_valid_o && rsp_exc_o == mtdm_pkg::EX_FUNC && !rsp_rd_en_o;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("unknown function not refused");
  property p_bad_qty;
    s_take ##0 req_func_i == mtdm_pkg::FC_RD_HOLD && req_qty_i > 16'h007d |=> rsp_exc_o == mtdm_pkg::EX_VALUE;
  endproperty
  a_bad_qty: assert property (p_bad_qty) else $error("126 registers accepted");
  property p_uninit;
    s_take ##0 !alt_mode_i && req_func_i == mtdm_pkg::FC_RD_INREG && req_qty_i == 16'h0001
      && {req_addr_i, 1'b1} >= {7'h00, in_size_i} |=> rsp_exc_o == mtdm_pkg::EX_ADDR;
  endproperty
  a_uninit: assert property (p_uninit) else $error("read beyond initialised input");
  property p_inreg_map;
    s_one_reg ##0 !alt_mode_i && req_func_i == mtdm_pkg::FC_RD_INREG && req_addr_i < 16'h0100
      |=> rsp_rd_en_o && rsp_rd_addr_o == {1'b0, $past(req_addr_i[7:0]), 1'b0};
  endproperty
  a_inreg_map: assert property (p_inreg_map) else $error("input register address wrong");
  property p_hold_map;
    s_one_reg ##0 !alt_mode_i && req_func_i == mtdm_pkg::FC_RD_HOLD && req_addr_i < 16'h0100
      |=> rsp_rd_addr_o == {1'b1, $past(req_addr_i[7:0]), 1'b0};
  endproperty
  a_hold_map: assert property (p_hold_map) else $error("holding register address wrong");
  property p_alt_reserved;
    s_take ##0 alt_mode_i && req_func_i == mtdm_pkg::FC_RD_HOLD && req_qty_i == 16'h0001
      && req_addr_i >= 16'h0100 && req_addr_i < 16'h0400 |=> rsp_exc_o == mtdm_pkg::EX_ADDR;
  endproperty
  a_alt_reserved: assert property (p_alt_reserved) else $error("reserved register accepted");
  property p_coil_msb;
    s_one_reg ##0 alt_mode_i && req_func_i == mtdm_pkg::FC_RD_COILS && req_addr_i == 16'h4000
      |=> rsp_rd_en_o && rsp_rd_addr_o == 10'h200 && rsp_rd_bit_o == 3'h7;
  endproperty
  a_coil_msb: assert property (p_coil_msb) else $error("first coil not bit 15");
  property p_out_only;
    s_take ##0 alt_mode_i && req_func_i == mtdm_pkg::FC_WR_REG && req_addr_i < 16'h0100
      |=> !rsp_wr_en_o ##1 !rsp_wr_en_o || rsp_valid_o;
  endproperty
  a_out_only: assert property (p_out_only) else $error("write to input area accepted");
endmodule : mtdm_mapper

// *** logic/mtdm_pkg.sv ***
// Constants for the Modbus-TCP function decoder and data mapper.
// Assumes a 1 KiB byte memory: input area low half, output area high half.
package mtdm_pkg;
  localparam logic [15:0] TCP_PORT = 16'h01f6;
  localparam int CONN_DFLT = 8;

  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_MCOIL = 8'h0f;
  localparam logic [7:0] FC_WR_MREG = 8'h10;
  localparam logic [7:0] FC_MASK_WR = 8'h16;
  localparam logic [7:0] FC_RW_REGS = 8'h17;

  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VALUE = 8'h03;

  localparam logic [15:0] QTY_ONE = 16'h0001;
  localparam logic [15:0] QTY_RD_REG = 16'h007d;
  localparam logic [15:0] QTY_RD_BIT = 16'h07d0;
  localparam logic [15:0] QTY_WR_BIT = 16'h0320;
  localparam logic [15:0] QTY_WR_REG_STD = 16'h0320;
  localparam logic [15:0] QTY_WR_REG_ALT = 16'h0064;
  localparam logic [15:0] QTY_RW_WR = 16'h0064;

  localparam logic [9:0] OUT_BASE = 10'h200;
  localparam logic [16:0] AREA_REGS = 17'h00100;
  localparam logic [16:0] ALT_OUT_FIRST = 17'h00400;
  localparam logic [16:0] ALT_OUT_END = 17'h00500;
  localparam int COIL_SHIFT = 4;
  localparam logic [2:0] BIT_MSB = 3'h7;

  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
endpackage : mtdm_pkg

// *** verification/mtdm_client.sv ***
// Client model: opens and closes connections, issues decoded requests.
// Assumes the mapper samples its inputs on the rising edge of core_clk_i.
`timescale 1ns/100ps
module mtdm_client (
  // Clock
  input wire logic core_clk_i,
  // Connection
  output logic conn_open_o,
  output logic [15:0] conn_port_o,
  output logic conn_close_o,
  output logic [2:0] conn_close_id_o,
  // Request
  output logic req_valid_o,
  output logic [2:0] req_conn_o,
  output logic [7:0] req_func_o,
  output logic [15:0] req_addr_o,
  output logic [15:0] req_qty_o,
  output logic [15:0] req_waddr_o,
  output logic [15:0] req_wqty_o,
  output logic [15:0] req_value_o
);
  initial begin
    {conn_open_o, conn_port_o, conn_close_o, conn_close_id_o} = '0;
    {req_valid_o, req_conn_o, req_func_o, req_addr_o, req_qty_o} = '0;
    {req_waddr_o, req_wqty_o, req_value_o} = '0;
  end

  task automatic conn_ev(input logic op, input logic [15:0] port, input logic cl, input logic [2:0] cid);
    @(posedge core_clk_i);
    {conn_open_o, conn_port_o, conn_close_o, conn_close_id_o} <= {op, port, cl, cid};
    @(posedge core_clk_i);
    {conn_open_o, conn_close_o} <= 2'h0;
    conn_port_o <= ~port;
  endtask : conn_ev

  task automatic send(input logic [2:0] c, input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
                      input logic [15:0] wa, input logic [15:0] wq, input logic [15:0] v);
    @(posedge core_clk_i);
    {req_valid_o, req_conn_o, req_func_o, req_addr_o, req_qty_o} <= {1'b1, c, f, a, q};
    {req_waddr_o, req_wqty_o, req_value_o} <= {wa, wq, v};
    @(posedge core_clk_i);
    req_valid_o <= 1'b0;
    // Released fields must not look valid
    {req_addr_o, req_qty_o, req_waddr_o, req_wqty_o, req_value_o} <= ~{a, q, wa, wq, v};
  endtask : send
endmodule : mtdm_client

// *** verification/tb.sv ***
// Self-checking bench for the request checker and address mapper.
// Assumes CONN of 8 and the client model driving the request side.
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic alt_mode = 1'b0;
  logic [9:0] in_size = 10'h200;
  logic [9:0] out_size = 10'h200;
  logic conn_open, conn_close, conn_ack, conn_nak, req_valid, rsp_valid, rsp_coil, rd_en, wr_en;
  logic [15:0] conn_port, req_addr, req_qty, req_waddr, req_wqty, req_value, rd_cnt, wr_cnt;
  logic [2:0] conn_close_id, conn_id, req_conn, rsp_conn, rd_bit, wr_bit;
  logic [7:0] req_func, rsp_func, rsp_exc;
  logic [9:0] rd_addr, wr_addr;
  logic [15:0] lfsr = 16'h696c;
  logic [15:0] ra, rq;
  logic [7:0] rf;
  logic [7:0] cf [5] = '{8'h01, 8'h02, 8'h05, 8'h0f, 8'h07};
  int err_count = 0;
  int n_compared = 0;

  always #12.5 core_clk = ~core_clk;

  mtdm_client mtdm_client_i (.core_clk_i(core_clk), .conn_open_o(conn_open), .conn_port_o(conn_port),
    .conn_close_o(conn_close), .conn_close_id_o(conn_close_id), .req_valid_o(req_valid),
    .req_conn_o(req_conn), .req_func_o(req_func), .req_addr_o(req_addr), .req_qty_o(req_qty),
    .req_waddr_o(req_waddr), .req_wqty_o(req_wqty), .req_value_o(req_value));

  mtdm_mapper #(.CONN(8)) mtdm_mapper_i (.core_clk_i(core_clk), .rst_i(rst), .conn_open_i(conn_open),
    .conn_port_i(conn_port), .conn_close_i(conn_close), .conn_close_id_i(conn_close_id),
    .conn_ack_o(conn_ack), .conn_nak_o(conn_nak), .conn_id_o(conn_id), .alt_mode_i(alt_mode),
    .in_size_i(in_size), .out_size_i(out_size), .req_valid_i(req_valid), .req_conn_i(req_conn),
    .req_func_i(req_func), .req_addr_i(req_addr), .req_qty_i(req_qty), .req_waddr_i(req_waddr),
    .req_wqty_i(req_wqty), .req_value_i(req_value), .rsp_valid_o(rsp_valid), .rsp_conn_o(rsp_conn),
    .rsp_func_o(rsp_func), .rsp_exc_o(rsp_exc), .rsp_coil_o(rsp_coil), .rsp_rd_en_o(rd_en),
    .rsp_rd_addr_o(rd_addr), .rsp_rd_bit_o(rd_bit), .rsp_rd_cnt_o(rd_cnt), .rsp_wr_en_o(wr_en),
    .rsp_wr_addr_o(wr_addr), .rsp_wr_bit_o(wr_bit), .rsp_wr_cnt_o(wr_cnt));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // Standard-mode register read, both areas fully initialised
  function automatic logic [7:0] exp_std(input logic [15:0] a, input logic [15:0] q);
    if (q == 16'h0000 || q > 16'h007d) return 8'h03;
    if ({1'b0, a} + {1'b0, q} > 17'h00100) return 8'h02;
    return 8'h00;
  endfunction : exp_std

  task automatic chk_val(input string name, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask : chk_bit

  task automatic conn(input logic op, input logic [15:0] port, input logic cl, input logic ea, input logic en,
                      input logic [2:0] eid);
    mtdm_client_i.conn_ev(op, port, cl, 3'h2);
    #1;
    chk_bit("conn_ack", ea, conn_ack);
    chk_bit("conn_nak", en, conn_nak);
    if (ea) chk_val("conn_id", {13'h0, eid}, {13'h0, conn_id});
  endtask : conn

  task automatic t(input logic alt, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
                   input logic [7:0] ee, input logic [9:0] ea, input logic [2:0] eb, input logic wr,
                   input logic [15:0] wa = 16'h0000, input logic [15:0] wq = 16'h0000,
                   input logic [15:0] v = 16'h0000);
    @(posedge core_clk);
    alt_mode <= alt;
    mtdm_client_i.send(3'h0, fc, a, q, wa, wq, v);
    #1;
    chk_bit("rsp_valid", 1'b1, rsp_valid);
    chk_val("rsp_func", {8'h00, fc}, {8'h00, rsp_func});
    chk_val("rsp_exc", {8'h00, ee}, {8'h00, rsp_exc});
    chk_bit("access_en", ee == 8'h00, wr ? wr_en : rd_en);
    chk_val("rsp_conn", 16'h0000, {13'h0, rsp_conn});
    chk_bit("rsp_coil", fc inside {8'h01, 8'h02, 8'h05, 8'h0f}, rsp_coil);
    if (ee == 8'h00) begin
      chk_val("count", !wr ? q : fc == 8'h17 ? wq : fc == 8'h0f || fc == 8'h10 ? q : 16'h0001, wr ? wr_cnt : rd_cnt);
      chk_val("addr", {6'h00, ea}, {6'h00, wr ? wr_addr : rd_addr});
      chk_val("bit", {13'h0, eb}, {13'h0, wr ? wr_bit : rd_bit});
    end
  endtask : t

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    conn(1'b1, 16'h01f6, 1'b0, 1'b1, 1'b0, 3'h0);
    conn(1'b1, 16'h01f7, 1'b0, 1'b0, 1'b1, 3'h0);
    for (int i = 1; i < 8; i++) conn(1'b1, 16'h01f6, 1'b0, 1'b1, 1'b0, 3'(i));
    conn(1'b1, 16'h01f6, 1'b0, 1'b0, 1'b1, 3'h0);
    conn(1'b0, 16'h01f6, 1'b1, 1'b0, 1'b0, 3'h0);
    conn(1'b1, 16'h01f6, 1'b0, 1'b1, 1'b0, 3'h2);
    conn(1'b0, 16'h01f6, 1'b1, 1'b0, 1'b0, 3'h0);
    mtdm_client_i.send(3'h2, 8'h04, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
    #1;
    chk_bit("dropped", 1'b0, rsp_valid);
    t(1'h0, 8'h04, 16'h0000, 16'h0001, 8'h00, 10'h000, 3'h7, 1'b0);
    t(1'h0, 8'h04, 16'h00ff, 16'h0001, 8'h00, 10'h1fe, 3'h7, 1'b0);
    t(1'h0, 8'h03, 16'h00ff, 16'h0001, 8'h00, 10'h3fe, 3'h7, 1'b0);
    t(1'h0, 8'h03, 16'h0000, 16'h007d, 8'h00, 10'h200, 3'h7, 1'b0);
    t(1'h0, 8'h03, 16'h0000, 16'h007e, 8'h03, 10'h000, 3'h7, 1'b0);
    t(1'h0, 8'h04, 16'h0000, 16'h0000, 8'h03, 10'h000, 3'h7, 1'b0);
    t(1'h0, 8'h03, 16'h00c8, 16'h003c, 8'h02, 10'h000, 3'h7, 1'b0);
    foreach (cf[k]) t(1'h0, cf[k], 16'h0000, 16'h0001, 8'h01, 10'h000, 3'h7, 1'b0);
    t(1'h0, 8'h06, 16'h0003, 16'h0001, 8'h00, 10'h206, 3'h7, 1'b1);
    t(1'h0, 8'h10, 16'h0000, 16'h0321, 8'h03, 10'h000, 3'h7, 1'b1);
    t(1'h0, 8'h10, 16'h0000, 16'h0320, 8'h02, 10'h000, 3'h7, 1'b1);
    t(1'h0, 8'h16, 16'h0001, 16'h0001, 8'h00, 10'h202, 3'h7, 1'b1);
    t(1'h0, 8'h17, 16'h0000, 16'h007d, 8'h00, 10'h200, 3'h7, 1'b1, 16'h0000, 16'h0064);
    t(1'h0, 8'h17, 16'h0000, 16'h0001, 8'h03, 10'h200, 3'h7, 1'b1, 16'h0000, 16'h0065);
    t(1'h1, 8'h01, 16'h0000, 16'h07d0, 8'h00, 10'h000, 3'h7, 1'b0);
    t(1'h1, 8'h01, 16'h0000, 16'h07d1, 8'h03, 10'h000, 3'h7, 1'b0);
    t(1'h1, 8'h02, 16'h4009, 16'h0001, 8'h00, 10'h201, 3'h6, 1'b0);
    t(1'h1, 8'h01, 16'h4000, 16'h0001, 8'h00, 10'h200, 3'h7, 1'b0);
    t(1'h1, 8'h05, 16'h4003, 16'h0001, 8'h00, 10'h200, 3'h4, 1'b1, 16'h0, 16'h0, 16'hff00);
    t(1'h1, 8'h05, 16'h4003, 16'h0001, 8'h03, 10'h200, 3'h4, 1'b1, 16'h0, 16'h0, 16'h1234);
    t(1'h1, 8'h05, 16'h0005, 16'h0001, 8'h02, 10'h000, 3'h7, 1'b1, 16'h0, 16'h0, 16'hff00);
    t(1'h1, 8'h03, 16'h012c, 16'h0001, 8'h02, 10'h000, 3'h7, 1'b0);
    t(1'h1, 8'h03, 16'h0400, 16'h0001, 8'h00, 10'h200, 3'h7, 1'b0);
    t(1'h1, 8'h10, 16'h0400, 16'h0065, 8'h03, 10'h000, 3'h7, 1'b1);
    t(1'h1, 8'h10, 16'h0401, 16'h0064, 8'h00, 10'h202, 3'h7, 1'b1);
    t(1'h1, 8'h0f, 16'h4000, 16'h0320, 8'h00, 10'h200, 3'h7, 1'b1);
    t(1'h1, 8'h0f, 16'h4000, 16'h0321, 8'h03, 10'h000, 3'h7, 1'b1);
    t(1'h1, 8'h06, 16'h000a, 16'h0001, 8'h02, 10'h000, 3'h7, 1'b1);
    t(1'h1, 8'h17, 16'h0000, 16'h007d, 8'h00, 10'h200, 3'h7, 1'b1, 16'h0400, 16'h0064);
    @(posedge core_clk);
    in_size <= 10'h100;
    t(1'h0, 8'h04, 16'h0080, 16'h0001, 8'h02, 10'h000, 3'h7, 1'b0);
    @(posedge core_clk);
    in_size <= 10'h200;
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsr_next(lfsr);
      rf = lfsr[0] ? 8'h03 : 8'h04;
      ra = {7'h00, lfsr[9:1]};
      rq = {9'h000, lfsr[15:9]};
      t(1'h0, rf, ra, rq, exp_std(ra, rq), 10'((lfsr[0] ? 16'h0200 : 16'h0000) + 2 * ra), 3'h7, 1'b0);
    end
    close_out();
  end
endmodule : tb
